// ### rtl/dcpt_params.svh
// Offsets, fields and reset values of the timer block
`ifndef DCPT_PARAMS_SVH
`define DCPT_PARAMS_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define DCPT_OFS_CTRL 6'h00
`define DCPT_OFS_CMD 6'h04
`define DCPT_OFS_PERIOD 6'h08
`define DCPT_OFS_COMPARE 6'h0c
`define DCPT_OFS_COUNT 6'h10
`define DCPT_OFS_CAPTURE 6'h14
`define DCPT_OFS_DEADBAND 6'h18
`define DCPT_OFS_DIVIDER 6'h1c
`define DCPT_OFS_STATUS 6'h20
`define DCPT_OFS_IRQ_CLR 6'h24
`define DCPT_OFS_IRQ_EN 6'h28
`define DCPT_OFS_STATE 6'h2c

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define DCPT_CTRL_RUN_LSB 0
`define DCPT_CTRL_CMP_LSB 2
`define DCPT_CTRL_SRC_LSB 5
`define DCPT_CTRL_COMPL_BIT 7
`define DCPT_CMD_START_BIT 0
`define DCPT_CMD_STOP_BIT 1
`define DCPT_ST_TC_BIT 0
`define DCPT_ST_CAP_BIT 1
`define DCPT_ST_KILL_BIT 2

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define DCPT_CTRL_RST 8'h00
`define DCPT_PERIOD_RST 16'hffff
`define DCPT_COMPARE_RST 16'h8000
`define DCPT_DEADBAND_RST 8'h00
`define DCPT_DIVIDER_RST 16'h0000
`define DCPT_IRQ_EN_RST 3'h0

`endif

// ### rtl/dcpt_pkg.sv
// Types shared by the timer block
package dcpt_pkg;
	typedef enum logic [1:0] {RUN_FREE, RUN_ONESHOT, RUN_GATED} dcpt_run_t;
	typedef enum logic [2:0] {
		less_than_compare,
		less_or_equal_compare,
		equal_compare,
		greater_or_equal_compare,
		greater_than_compare
	} dcpt_cmp_t;
	typedef enum logic [1:0] {SRC_SYS, SRC_DIV, SRC_EXT} dcpt_src_t;
	typedef enum logic {ST_IDLE, ST_RUN} dcpt_state_t;
endpackage

// ### rtl/dcpt_sync.sv
// Two-stage synchroniser for routed input pins
`timescale 1ns/1ns
module dcpt_sync #(
	parameter int W = 5
) (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	// ------------------------------------------------------------
	// One pair of flip-flops per bit
	// ------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic meta_r;
			logic stable_r;
			// First stage feeds only the second stage
			always_ff @(posedge clk_in or negedge resetn_in) begin
				if (!resetn_in) begin
					meta_r <= 1'b0;
					stable_r <= 1'b0;
				end else begin
					meta_r <= async_in[i];
					stable_r <= meta_r;
				end
			end
			assign sync_out[i] = stable_r;
		end
	endgenerate
endmodule

// ### rtl/dcpt_deadband.sv
// Complementary output pair with programmable dead time
`timescale 1ns/1ns
module dcpt_deadband (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic tick_in,
	input wire logic cmp_in,
	input wire logic kill_in,
	input wire logic [7:0] dead_in,
	output logic hi_out,
	output logic lo_out
);
	logic prev_r;
	logic [7:0] dcnt_r;
	logic [7:0] dcnt_nxt;
	logic hi_r;
	logic lo_r;
	logic edge_w;
	logic quiet_w;

	// ------------------------------------------------------------
	// Dead time counter, reloaded on every compare edge
	// ------------------------------------------------------------
	assign edge_w = cmp_in != prev_r;
	assign quiet_w = !edge_w && dcnt_r == 8'h00;
	assign dcnt_nxt = edge_w ? dead_in :
		(tick_in && dcnt_r != 8'h00) ? dcnt_r - 8'h01 : dcnt_r;

	// Both outputs stay low while the dead time runs
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			prev_r <= 1'b0;
			dcnt_r <= 8'h00;
			hi_r <= 1'b0;
			lo_r <= 1'b0;
		end else begin
			prev_r <= cmp_in;
			dcnt_r <= dcnt_nxt;
			hi_r <= !kill_in && quiet_w && cmp_in;
			lo_r <= !kill_in && quiet_w && !cmp_in;
		end
	end

	assign hi_out = hi_r;
	assign lo_out = lo_r;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!resetn_in);

	property p_no_overlap;
		!(hi_r && lo_r);
	endproperty
	a_no_overlap: assert property (p_no_overlap)
		else $error("Both PWM outputs active");

	sequence s_cmp_edge;
		cmp_in != prev_r;
	endsequence
	property p_dead_gap;
		s_cmp_edge |=> !hi_r && !lo_r;
	endproperty
	a_dead_gap: assert property (p_dead_gap)
		else $error("No dead gap after compare edge");
endmodule

// ### rtl/dcpt_timer.sv
// Down-counting timer, counter and PWM with Avalon-MM registers
//
// Local design decisions: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ns
`include "dcpt_params.svh"
module dcpt_timer (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic [5:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	input wire logic count_reset_in,
	input wire logic capture_in,
	input wire logic count_enable_in,
	input wire logic kill_in,
	input wire logic ext_clk_in,
	output logic cmp_out,
	output logic cmp_n_out,
	output logic tc_out,
	output logic pwm_hi_out,
	output logic pwm_lo_out,
	output logic irq_out
);
	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic [4:0] pins_w;
	logic [4:0] syn_w;
	logic rst_s, cap_s, en_s, kill_s, ext_s;
	logic cap_d_r, kill_d_r, ext_d_r;
	logic wait_r;
	logic [31:0] rdata_r;
	logic [31:0] rmux_w;
	logic wr_fire, rd_load;
	logic wr_ctrl, wr_cmd, wr_period, wr_compare, wr_dead, wr_div;
	logic wr_clr, wr_ien;
	logic [7:0] ctrl_r;
	logic [15:0] period_r, compare_r, div_r, div_cnt_r, div_cnt_nxt;
	logic [15:0] count_r, count_nxt, capture_r;
	logic [7:0] dead_r;
	logic [2:0] status_r, status_nxt, ien_r, ev_w, clr_w;
	logic irq_r;
	dcpt_pkg::dcpt_run_t run_mode;
	dcpt_pkg::dcpt_cmp_t cmp_mode;
	dcpt_pkg::dcpt_src_t src_sel;
	dcpt_pkg::dcpt_state_t state_r, state_nxt;
	logic start_cmd, stop_cmd;
	logic div_hit, ext_rise, cap_rise, kill_rise, tick;
	logic advance, at_zero, tc_event;
	logic cmp_raw, cmp_r, cmp_n_r, tc_r;

	// ------------------------------------------------------------
	// Pin synchronisation and edge detection
	// ------------------------------------------------------------
	assign pins_w = {ext_clk_in, kill_in, count_enable_in, capture_in,
		count_reset_in};
	dcpt_sync #(.W(5)) u_sync (
		.clk_in(clk_in),
		.resetn_in(resetn_in),
		.async_in(pins_w),
		.sync_out(syn_w)
	);
	assign rst_s = syn_w[0];
	assign cap_s = syn_w[1];
	assign en_s = syn_w[2];
	assign kill_s = syn_w[3];
	assign ext_s = syn_w[4];
	assign ext_rise = ext_s && !ext_d_r;
	assign cap_rise = cap_s && !cap_d_r;
	assign kill_rise = kill_s && !kill_d_r;

	// Delayed copies for edge detection
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cap_d_r <= 1'b0;
			kill_d_r <= 1'b0;
			ext_d_r <= 1'b0;
		end else begin
			cap_d_r <= cap_s;
			kill_d_r <= kill_s;
			ext_d_r <= ext_s;
		end
	end

	// ------------------------------------------------------------
	// Avalon-MM slave: one wait cycle per access
	// ------------------------------------------------------------
	assign wr_fire = avs_write_in && !wait_r;
	assign rd_load = avs_read_in && wait_r;
	assign wr_ctrl = wr_fire && avs_address_in == `DCPT_OFS_CTRL;
	assign wr_cmd = wr_fire && avs_address_in == `DCPT_OFS_CMD;
	assign wr_period = wr_fire && avs_address_in == `DCPT_OFS_PERIOD;
	assign wr_compare = wr_fire && avs_address_in == `DCPT_OFS_COMPARE;
	assign wr_dead = wr_fire && avs_address_in == `DCPT_OFS_DEADBAND;
	assign wr_div = wr_fire && avs_address_in == `DCPT_OFS_DIVIDER;
	assign wr_clr = wr_fire && avs_address_in == `DCPT_OFS_IRQ_CLR;
	assign wr_ien = wr_fire && avs_address_in == `DCPT_OFS_IRQ_EN;
	assign start_cmd = wr_cmd && avs_writedata_in[`DCPT_CMD_START_BIT];
	assign stop_cmd = wr_cmd && avs_writedata_in[`DCPT_CMD_STOP_BIT];

	// Read data selection; unmapped and write-only offsets read zero
	assign rmux_w =
		avs_address_in == `DCPT_OFS_CTRL ? {24'h000000, ctrl_r} :
		avs_address_in == `DCPT_OFS_PERIOD ? {16'h0000, period_r} :
		avs_address_in == `DCPT_OFS_COMPARE ? {16'h0000, compare_r} :
		avs_address_in == `DCPT_OFS_COUNT ? {16'h0000, count_r} :
		avs_address_in == `DCPT_OFS_CAPTURE ? {16'h0000, capture_r} :
		avs_address_in == `DCPT_OFS_DEADBAND ? {24'h000000, dead_r} :
		avs_address_in == `DCPT_OFS_DIVIDER ? {16'h0000, div_r} :
		avs_address_in == `DCPT_OFS_STATUS ? {29'h00000000, status_r} :
		avs_address_in == `DCPT_OFS_IRQ_EN ? {29'h00000000, ien_r} :
		avs_address_in == `DCPT_OFS_STATE ?
			{31'h00000000, state_r == dcpt_pkg::ST_RUN} :
		32'h00000000;

	// Waitrequest drops for one cycle after a request appears
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			wait_r <= 1'b1;
			rdata_r <= 32'h00000000;
		end else begin
			wait_r <= !((avs_read_in || avs_write_in) && wait_r);
			if (rd_load) begin
				rdata_r <= rmux_w;
			end
		end
	end

	// Software-written configuration
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ctrl_r <= `DCPT_CTRL_RST;
			period_r <= `DCPT_PERIOD_RST;
			compare_r <= `DCPT_COMPARE_RST;
			dead_r <= `DCPT_DEADBAND_RST;
			div_r <= `DCPT_DIVIDER_RST;
			ien_r <= `DCPT_IRQ_EN_RST;
		end else begin
			if (wr_ctrl) ctrl_r <= avs_writedata_in[7:0];
			if (wr_period) period_r <= avs_writedata_in[15:0];
			if (wr_compare) compare_r <= avs_writedata_in[15:0];
			if (wr_dead) dead_r <= avs_writedata_in[7:0];
			if (wr_div) div_r <= avs_writedata_in[15:0];
			if (wr_ien) ien_r <= avs_writedata_in[2:0];
		end
	end

	// ------------------------------------------------------------
	// Count clock selection
	// ------------------------------------------------------------
	assign run_mode = dcpt_pkg::dcpt_run_t'(ctrl_r[`DCPT_CTRL_RUN_LSB +: 2]);
	assign cmp_mode = dcpt_pkg::dcpt_cmp_t'(ctrl_r[`DCPT_CTRL_CMP_LSB +: 3]);
	assign src_sel = dcpt_pkg::dcpt_src_t'(ctrl_r[`DCPT_CTRL_SRC_LSB +: 2]);
	assign div_hit = div_cnt_r == div_r;
	assign div_cnt_nxt = div_hit ? 16'h0000 : div_cnt_r + 16'h0001;
	assign tick = src_sel == dcpt_pkg::SRC_SYS ? 1'b1 :
		src_sel == dcpt_pkg::SRC_DIV ? div_hit :
		src_sel == dcpt_pkg::SRC_EXT ? ext_rise : 1'b0;

	// ------------------------------------------------------------
	// Down counter and run state
	// ------------------------------------------------------------
	assign advance = tick && state_r == dcpt_pkg::ST_RUN &&
		(run_mode != dcpt_pkg::RUN_GATED || en_s);
	assign at_zero = count_r == 16'h0000;
	assign tc_event = advance && at_zero;
	assign count_nxt = (start_cmd || rst_s) ? period_r :
		tc_event ? period_r :
		advance ? count_r - 16'h0001 : count_r;

	// Run state: start wins over stop; one-shot stops at terminal count
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			dcpt_pkg::ST_IDLE: begin
				if (start_cmd) state_nxt = dcpt_pkg::ST_RUN;
			end
			dcpt_pkg::ST_RUN: begin
				if (start_cmd) begin
					state_nxt = dcpt_pkg::ST_RUN;
				end else if (stop_cmd) begin
					state_nxt = dcpt_pkg::ST_IDLE;
				end else if (tc_event &&
					run_mode == dcpt_pkg::RUN_ONESHOT) begin
					state_nxt = dcpt_pkg::ST_IDLE;
				end
			end
			default: state_nxt = dcpt_pkg::ST_IDLE;
		endcase
	end

	// Counter, divider and capture registers
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_r <= dcpt_pkg::ST_IDLE;
			count_r <= `DCPT_PERIOD_RST;
			div_cnt_r <= 16'h0000;
			capture_r <= 16'h0000;
		end else begin
			state_r <= state_nxt;
			count_r <= count_nxt;
			div_cnt_r <= div_cnt_nxt;
			if (cap_rise) capture_r <= count_r;
		end
	end

	// ------------------------------------------------------------
	// Compare stage and outputs
	// ------------------------------------------------------------
	assign cmp_raw =
		cmp_mode == dcpt_pkg::less_than_compare ? count_r < compare_r :
		cmp_mode == dcpt_pkg::less_or_equal_compare ? count_r <= compare_r :
		cmp_mode == dcpt_pkg::equal_compare ? count_r == compare_r :
		cmp_mode == dcpt_pkg::greater_or_equal_compare ?
			count_r >= compare_r :
		cmp_mode == dcpt_pkg::greater_than_compare ? count_r > compare_r :
		1'b0;

	// Kill overrides both compare outputs
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cmp_r <= 1'b0;
			cmp_n_r <= 1'b0;
			tc_r <= 1'b0;
		end else begin
			cmp_r <= cmp_raw && !kill_s;
			cmp_n_r <= ctrl_r[`DCPT_CTRL_COMPL_BIT] && !cmp_raw &&
				!kill_s;
			tc_r <= tc_event;
		end
	end

	dcpt_deadband u_dead (
		.clk_in(clk_in),
		.resetn_in(resetn_in),
		.tick_in(tick),
		.cmp_in(cmp_raw),
		.kill_in(kill_s),
		.dead_in(dead_r),
		.hi_out(pwm_hi_out),
		.lo_out(pwm_lo_out)
	);

	// ------------------------------------------------------------
	// Interrupt status: set wins over clear
	// ------------------------------------------------------------
	assign ev_w = {kill_rise, cap_rise, tc_event};
	assign clr_w = wr_clr ? avs_writedata_in[2:0] : 3'h0;
	assign status_nxt = (status_r & ~clr_w) | ev_w;

	// Sticky flags and level interrupt
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			status_r <= 3'h0;
			irq_r <= 1'b0;
		end else begin
			status_r <= status_nxt;
			irq_r <= |(status_r & ien_r);
		end
	end

	assign avs_readdata_out = rdata_r;
	assign avs_waitrequest_out = wait_r;
	assign cmp_out = cmp_r;
	assign cmp_n_out = cmp_n_r;
	assign tc_out = tc_r;
	assign irq_out = irq_r;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!resetn_in);

	property p_down_only;
		advance && !at_zero && !start_cmd && !rst_s |=>
			count_r == $past(count_r) - 16'h0001;
	endproperty
	a_down_only: assert property (p_down_only)
		else $error("Counter did not step down by one");

	property p_reload;
		start_cmd || rst_s || tc_event |=> count_r == $past(period_r);
	endproperty
	a_reload: assert property (p_reload)
		else $error("Period not reloaded");

	property p_compl;
		ctrl_r[`DCPT_CTRL_COMPL_BIT] && !kill_s |=> cmp_n_r == !cmp_r;
	endproperty
	a_compl: assert property (p_compl)
		else $error("Inverted compare output wrong");

	property p_cmp_eq;
		cmp_mode == dcpt_pkg::equal_compare && !kill_s |=>
			cmp_r == $past(count_r == compare_r);
	endproperty
	a_cmp_eq: assert property (p_cmp_eq)
		else $error("Equal compare mismatch");

	property p_free_runs;
		run_mode == dcpt_pkg::RUN_FREE && tc_event && !stop_cmd |=>
			state_r == dcpt_pkg::ST_RUN;
	endproperty
	a_free_runs: assert property (p_free_runs)
		else $error("Free-running counter stopped");

	sequence s_last_period;
		run_mode == dcpt_pkg::RUN_ONESHOT && tc_event && !start_cmd;
	endsequence
	property p_oneshot;
		s_last_period |=> state_r == dcpt_pkg::ST_IDLE ##1
			(state_r == dcpt_pkg::ST_IDLE || $past(start_cmd));
	endproperty
	a_oneshot: assert property (p_oneshot)
		else $error("One-shot did not halt");

	property p_gated_hold;
		run_mode == dcpt_pkg::RUN_GATED && !en_s && !start_cmd && !rst_s
			|=> $stable(count_r);
	endproperty
	a_gated_hold: assert property (p_gated_hold)
		else $error("Gated counter moved without enable");

	property p_capture;
		cap_rise |=> capture_r == $past(count_r);
	endproperty
	a_capture: assert property (p_capture)
		else $error("Capture value wrong");

	// Compare and PWM registers both see the synced kill with one register
	property p_kill;
		kill_s |=> !cmp_r && !cmp_n_r && !pwm_hi_out && !pwm_lo_out;
	endproperty
	a_kill: assert property (p_kill)
		else $error("Kill did not force outputs off");

	property p_tc_once;
		tc_r |-> $past(at_zero) && $past(advance);
	endproperty
	a_tc_once: assert property (p_tc_once)
		else $error("Terminal count pulse without zero");
endmodule

// ### verification/dcpt_pins_model.sv
// Model of the routed logic that drives the timer's input pins
`timescale 1ns/1ns
module dcpt_pins_model (
	input wire logic clk_in,
	output logic count_reset_out,
	output logic capture_out,
	output logic count_enable_out,
	output logic kill_out,
	output logic ext_clk_out
);
	// ---------------------------------------------------------------
	// Idle levels
	// ---------------------------------------------------------------
	// All pins quiet from time zero; the external clock stands low
	initial begin
		count_reset_out = 1'b0;
		capture_out = 1'b0;
		count_enable_out = 1'b0;
		kill_out = 1'b0;
		ext_clk_out = 1'b0;
	end

	// ---------------------------------------------------------------
	// Pin drivers
	// ---------------------------------------------------------------
	// Level pins change just after a clock edge
	task automatic drive_levels(input logic rst, input logic en,
		input logic kill);
		@(posedge clk_in);
		count_reset_out <= rst;
		count_enable_out <= en;
		kill_out <= kill;
	endtask

	// Capture pulse held long enough to pass the synchroniser
	task automatic pulse_capture();
		@(posedge clk_in);
		capture_out <= 1'b1;
		repeat (3) @(posedge clk_in);
		capture_out <= 1'b0;
	endtask

	// Counted rising edges on the routed count clock
	task automatic ext_edges(input int n);
		repeat (n) begin
			@(posedge clk_in);
			ext_clk_out <= 1'b1;
			repeat (3) @(posedge clk_in);
			ext_clk_out <= 1'b0;
			repeat (2) @(posedge clk_in);
		end
	endtask
endmodule

// ### verification/down_counter_pwm_timer_tb.sv
// Self-checking bench for the down-counting timer block
`timescale 1ns/1ns
`include "dcpt_params.svh"
module down_counter_pwm_timer_tb;
	logic clk_in, resetn_in;
	logic [5:0] avs_address_in;
	logic avs_read_in, avs_write_in;
	logic [31:0] avs_writedata_in, avs_readdata_out, rdata;
	logic avs_waitrequest_out;
	logic count_reset_in, capture_in, count_enable_in, kill_in, ext_clk_in;
	logic cmp_out, cmp_n_out, tc_out, pwm_hi_out, pwm_lo_out, irq_out;
	logic [15:0] seed, c;
	logic [31:0] p;
	int errors, tests_run, gap;

	// ---------------------------------------------------------------
	// Design, pin model, clock and reset
	// ---------------------------------------------------------------
	dcpt_timer uut (.clk_in(clk_in), .resetn_in(resetn_in),
		.avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
		.avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
		.avs_readdata_out(avs_readdata_out),
		.avs_waitrequest_out(avs_waitrequest_out),
		.count_reset_in(count_reset_in), .capture_in(capture_in),
		.count_enable_in(count_enable_in), .kill_in(kill_in),
		.ext_clk_in(ext_clk_in), .cmp_out(cmp_out), .cmp_n_out(cmp_n_out),
		.tc_out(tc_out), .pwm_hi_out(pwm_hi_out), .pwm_lo_out(pwm_lo_out),
		.irq_out(irq_out));
	dcpt_pins_model pins (.clk_in(clk_in), .count_reset_out(count_reset_in),
		.capture_out(capture_in), .count_enable_out(count_enable_in),
		.kill_out(kill_in), .ext_clk_out(ext_clk_in));

	// Free-running clock and bus idle levels
	initial begin
		clk_in = 1'b0;
		resetn_in = 1'b0;
		avs_address_in = 6'h00;
		avs_read_in = 1'b0;
		avs_write_in = 1'b0;
		avs_writedata_in = 32'h0;
		forever #5 clk_in = ~clk_in;
	end

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	// Step of the bench's pseudo-random source
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// Expected compare result for one mode
	function automatic logic exp_cmp(input logic [2:0] m,
		input logic [15:0] cnt, input logic [15:0] k);
		case (m)
			dcpt_pkg::less_than_compare: return cnt < k;
			dcpt_pkg::less_or_equal_compare: return cnt <= k;
			dcpt_pkg::equal_compare: return cnt == k;
			dcpt_pkg::greater_or_equal_compare: return cnt >= k;
			dcpt_pkg::greater_than_compare: return cnt > k;
			default: return 1'b0;
		endcase
	endfunction

	// Compare one value against its expectation
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One Avalon transfer, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [5:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clk_in);
		avs_address_in <= a;
		avs_write_in <= wr;
		avs_read_in <= ~wr;
		avs_writedata_in <= d;
		n = 0;
		@(posedge clk_in);
		while (avs_waitrequest_out !== 1'b0 && n < 50) begin
			n++;
			@(posedge clk_in);
		end
		check(32'(n < 50), 32'h1);
		rdata = avs_readdata_out;
		avs_read_in <= 1'b0;
		avs_write_in <= 1'b0;
	endtask

	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		check(rdata, e);
	endtask

	// Bounded wait for a terminal-count pulse
	task automatic wait_tc();
		int n;
		n = 0;
		@(posedge clk_in);
		while (tc_out !== 1'b1 && n < 400) begin
			n++;
			@(posedge clk_in);
		end
		check(32'(n < 400), 32'h1);
	endtask

	// Verdict and end of run
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Both PWM sides must never be active together
	always @(posedge clk_in) begin
		if (resetn_in) begin
			check({31'h0, pwm_hi_out & pwm_lo_out}, 32'h0);
		end
	end

	// Watchdog against a hung handshake
	initial begin
		repeat (60000) @(posedge clk_in);
		errors++;
		end_of_test();
	end

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	initial begin
		errors = 0;
		tests_run = 0;
		seed = 16'h841b;
		repeat (2) @(posedge clk_in);
		resetn_in <= 1'b1;
		// Reset values, write-only and unmapped places
		rd_chk(`DCPT_OFS_PERIOD, 32'(`DCPT_PERIOD_RST));
		rd_chk(`DCPT_OFS_COMPARE, 32'(`DCPT_COMPARE_RST));
		rd_chk(`DCPT_OFS_DEADBAND, 32'(`DCPT_DEADBAND_RST));
		rd_chk(`DCPT_OFS_COUNT, 32'h0000ffff);
		rd_chk(`DCPT_OFS_IRQ_EN, 32'(`DCPT_IRQ_EN_RST));
		rd_chk(`DCPT_OFS_STATE, 32'h0);
		rd_chk(`DCPT_OFS_CMD, 32'h0);
		rd_chk(6'h30, 32'h0);
		// Free run: period reload spacing, pulse width, interrupt path
		for (int i = 0; i < 3; i++) begin
			seed = lfsr(seed);
			p = 32'(seed[2:0]) + 32'h1;
			wr(`DCPT_OFS_CTRL, 32'h0);
			wr(`DCPT_OFS_PERIOD, p);
			wr(`DCPT_OFS_IRQ_CLR, 32'h7);
			wr(`DCPT_OFS_IRQ_EN, 32'h1);
			wr(`DCPT_OFS_CMD, 32'h1);
			wait_tc();
			@(posedge clk_in);
			check({31'h0, tc_out}, 32'h0);
			gap = 1;
			while (tc_out !== 1'b1 && gap < 50) begin
				gap++;
				@(posedge clk_in);
			end
			check(32'(gap), p + 32'h1);
			repeat (2) @(posedge clk_in);
			check({31'h0, irq_out}, 32'h1);
			wr(`DCPT_OFS_CMD, 32'h2);
			bus(1'b0, `DCPT_OFS_STATUS, 32'h0);
			check(rdata & 32'h1, 32'h1);
			wr(`DCPT_OFS_IRQ_EN, 32'h0);
			repeat (2) @(posedge clk_in);
			check({31'h0, irq_out}, 32'h0);
			wr(`DCPT_OFS_IRQ_EN, 32'h1);
			repeat (2) @(posedge clk_in);
			check({31'h0, irq_out}, 32'h1);
			wr(`DCPT_OFS_IRQ_CLR, 32'h1);
			repeat (2) @(posedge clk_in);
			check({31'h0, irq_out}, 32'h0);
		end
		// Every compare mode around the stopped count
		for (int m = 0; m < 5; m++) begin
			seed = lfsr(seed);
			wr(`DCPT_OFS_CTRL, 32'h80 | 32'(m << 2));
			wr(`DCPT_OFS_PERIOD, 32'h1f);
			wr(`DCPT_OFS_CMD, 32'h1);
			repeat (int'(seed[4:0]) + 3) @(posedge clk_in);
			wr(`DCPT_OFS_CMD, 32'h2);
			bus(1'b0, `DCPT_OFS_COUNT, 32'h0);
			c = rdata[15:0];
			for (int j = 0; j < 3; j++) begin
				wr(`DCPT_OFS_COMPARE, 32'(c + 16'(j) - 16'h1));
				repeat (4) @(posedge clk_in);
				check({31'h0, cmp_out},
					32'(exp_cmp(m[2:0], c, c + 16'(j) - 16'h1)));
				check({31'h0, cmp_n_out},
					32'(!exp_cmp(m[2:0], c, c + 16'(j) - 16'h1)));
			end
		end
		// Capture of a wide count, then kill over a true compare
		seed = lfsr(seed);
		wr(`DCPT_OFS_CTRL, 32'h90);
		wr(`DCPT_OFS_COMPARE, 32'h0);
		wr(`DCPT_OFS_PERIOD, {16'h0, seed | 16'h8000});
		wr(`DCPT_OFS_CMD, 32'h1);
		repeat (9) @(posedge clk_in);
		wr(`DCPT_OFS_CMD, 32'h2);
		bus(1'b0, `DCPT_OFS_COUNT, 32'h0);
		c = rdata[15:0];
		pins.pulse_capture();
		repeat (4) @(posedge clk_in);
		rd_chk(`DCPT_OFS_CAPTURE, {16'h0, c});
		bus(1'b0, `DCPT_OFS_STATUS, 32'h0);
		check(rdata & 32'h2, 32'h2);
		check({31'h0, cmp_out}, 32'h1);
		pins.drive_levels(1'b0, 1'b0, 1'b1);
		repeat (5) @(posedge clk_in);
		check({28'h0, cmp_out, cmp_n_out, pwm_hi_out, pwm_lo_out},
			32'h0);
		bus(1'b0, `DCPT_OFS_STATUS, 32'h0);
		check(rdata & 32'h4, 32'h4);
		pins.drive_levels(1'b0, 1'b0, 1'b0);
		repeat (5) @(posedge clk_in);
		check({31'h0, cmp_out}, 32'h1);
		// Gated mode holds without enable, counts down with it
		wr(`DCPT_OFS_CTRL, 32'h2);
		wr(`DCPT_OFS_PERIOD, 32'h100);
		wr(`DCPT_OFS_CMD, 32'h1);
		repeat (10) @(posedge clk_in);
		rd_chk(`DCPT_OFS_COUNT, 32'h100);
		pins.drive_levels(1'b0, 1'b1, 1'b0);
		repeat (10) @(posedge clk_in);
		bus(1'b0, `DCPT_OFS_COUNT, 32'h0);
		check(32'(rdata < 32'h100), 32'h1);
		// Reset pin reloads the period while counting
		wr(`DCPT_OFS_CTRL, 32'h0);
		wr(`DCPT_OFS_PERIOD, 32'h40);
		wr(`DCPT_OFS_CMD, 32'h1);
		repeat (20) @(posedge clk_in);
		pins.drive_levels(1'b1, 1'b0, 1'b0);
		repeat (5) @(posedge clk_in);
		rd_chk(`DCPT_OFS_COUNT, 32'h40);
		pins.drive_levels(1'b0, 1'b0, 1'b0);
		repeat (10) @(posedge clk_in);
		bus(1'b0, `DCPT_OFS_COUNT, 32'h0);
		check(32'(rdata < 32'h40), 32'h1);
		// One-shot halts after one period and restarts on command
		wr(`DCPT_OFS_CTRL, 32'h1);
		wr(`DCPT_OFS_PERIOD, 32'h20);
		wr(`DCPT_OFS_CMD, 32'h1);
		wait_tc();
		repeat (3) @(posedge clk_in);
		rd_chk(`DCPT_OFS_STATE, 32'h0);
		rd_chk(`DCPT_OFS_COUNT, 32'h20);
		wr(`DCPT_OFS_CMD, 32'h1);
		rd_chk(`DCPT_OFS_STATE, 32'h1);
		// Routed external clock source counts its rising edges
		wr(`DCPT_OFS_CTRL, 32'h40);
		wr(`DCPT_OFS_PERIOD, 32'h50);
		wr(`DCPT_OFS_CMD, 32'h1);
		repeat (4) @(posedge clk_in);
		pins.ext_edges(5);
		repeat (6) @(posedge clk_in);
		rd_chk(`DCPT_OFS_COUNT, 32'h4b);
		// Divided source: one tick every DIVIDER+1 clocks, 43 clocks run
		wr(`DCPT_OFS_CTRL, 32'h20);
		wr(`DCPT_OFS_DIVIDER, 32'h3);
		wr(`DCPT_OFS_PERIOD, 32'h50);
		wr(`DCPT_OFS_CMD, 32'h1);
		repeat (40) @(posedge clk_in);
		wr(`DCPT_OFS_CMD, 32'h2);
		rd_chk(`DCPT_OFS_DIVIDER, 32'h3);
		bus(1'b0, `DCPT_OFS_COUNT, 32'h0);
		check(32'(rdata == 32'h45 || rdata == 32'h46), 32'h1);
		// Deadband: one compare latency, dead+1 both low, one sample lag
		seed = lfsr(seed);
		p = 32'(seed[2:0]) + 32'h1;
		wr(`DCPT_OFS_CTRL, 32'h0);
		wr(`DCPT_OFS_DEADBAND, p);
		repeat (20) @(posedge clk_in);
		check({30'h0, pwm_hi_out, pwm_lo_out}, 32'h1);
		for (int k = 0; k < 2; k++) begin
			wr(`DCPT_OFS_COMPARE, k == 0 ? 32'hffff : 32'h0);
			gap = 1;
			@(posedge clk_in);
			while ((k == 0 ? pwm_hi_out : pwm_lo_out) !== 1'b1 &&
				gap < 300) begin
				gap++;
				@(posedge clk_in);
			end
			check(32'(gap), p + 32'h3);
			check({31'h0, k == 0 ? pwm_lo_out : pwm_hi_out}, 32'h0);
		end
		end_of_test();
	end
endmodule
